// ===== shared/hlc_consts.vh
// register offsets, field positions, fuse map and link constants of the host link config bank
`ifndef HLC_CONSTS_VH
`define HLC_CONSTS_VH

`define HLC_ADDR_W 9
`define HLC_OFS_FUSE_ADDR 9'h102
`define HLC_OFS_FUSE_DATA 9'h103
`define HLC_OFS_TEMP_OFS 9'h104
`define HLC_OFS_LINK_SETUP 9'h105
`define HLC_OFS_LINK_CFG 9'h106

`define HLC_RST_BYTE 8'h00

// host_link_setup fields
`define HLC_SETUP_BASE_HI 7
`define HLC_SETUP_BASE_LO 4
`define HLC_SETUP_RDPOL 3
`define HLC_SETUP_CPHA 2
`define HLC_SETUP_CPOL 1
`define HLC_SETUP_SELPOL 0

// host_link_and_output_config fields
`define HLC_CFG_TWO_WIRE 7
`define HLC_CFG_HS_CONT 6
`define HLC_CFG_FAST_PLUS 5
`define HLC_CFG_IRQ_POL 3
`define HLC_CFG_DRIVE 2
`define HLC_CFG_HOST_MASK 8'h7f

// 2-wire address low nibble
`define HLC_TW_HS_BIT 2
`define HLC_TW_PAGE_BIT 1
`define HLC_TW_RW_BIT 0
`define HLC_TW_ZERO_BIT 3
`define HLC_DEFAULT_BASE 4'hb
`define HLC_BASE_UNPROG 4'h0

// fuse array map of the application range
`define HLC_FUSE_T_OFFSET 8'h04
`define HLC_FUSE_SETUP 8'h05
`define HLC_FUSE_CFG 8'h06
`define HLC_FUSE_LOCK 8'h18
`define HLC_FUSE_APP_FIRST 8'h04
`define HLC_FUSE_APP_LAST 8'h18
`define HLC_LOAD_LAST 2'h3

// unlock sequence: chip select byte then three keys
`define HLC_CHIP_CODE 8'h5a
`define HLC_KEY0 8'h12
`define HLC_KEY1 8'h34
`define HLC_KEY2 8'h56
`define HLC_SEQ_LAST 2'h3

`endif

// ===== logic/hlc_fuse_mem.v
// fuse array model: 256 bytes, registered read data
`timescale 1ns/1ps
module hlc_fuse_mem (
    input wire sys_clk,
    input wire rd_en,
    input wire [7:0] rd_addr,
    output reg [7:0] rd_data,
    input wire wr_en,
    input wire [7:0] wr_addr,
    input wire [7:0] wr_data
);
    reg [7:0] mem [0:255];
    integer i;

    // blank fuses read as zero until something is fused
    initial
    begin
        for (i = 0; i < 256; i = i + 1)
        begin
            mem[i] = 8'h00;
        end
    end

    // fusing only sets bits, never clears them
    always @(posedge sys_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= mem[wr_addr] | wr_data;
        end
        if (rd_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ===== logic/hlc_host_link_config.v
// host link configuration and fuse access register bank
// Overview of operation
// - 8-bit read/write fuse address register, shared with companion chips.
// - 8-bit read/write fuse data register holding byte read or to be fused.
// - chip select byte then three key bytes written to address register unlock access.
// - temperature calibration is an 8-bit signed offset.
// - temperature offset is read-only, loaded from fuses only.
// - setup bits 7..4 hold the 2-wire base nibble, device forms low nibble.
// - primary link answers base+0/1 for pages 0-1, base+2/3 for pages 2-3.
// - high-speed link answers base+4/5 for pages 0-1, base+6/7 for pages 2-3.
// - base nibble zero means unprogrammed, hardware default address used.
// - setup bit 3 chooses which read/write flag value means read.
// - setup bit 2 chooses the 4-wire sampling clock phase.
// - setup bit 1 gives the 4-wire clock idle level.
// - setup bit 0 gives the 4-wire chip select active level.
// - interface fields writable only when unmarked and application lock clear.
// - config bit 7 chooses 4-wire (0) or 2-wire (1) host link.
// - config bit 6 puts primary 2-wire link in continuous high speed.
// - config bit 5 selects fast-mode-plus timing on the primary link.
// - config bit 3 sets interrupt output polarity, 1 active high.
// - config bit 2 selects push-pull or open drain for reset and interrupt.
// - application lock set forbids further fusing of the application range.
// - reload request re-reads application registers and lock bit from fuses.
`timescale 1ns/1ps
`include "hlc_consts.vh"
module hlc_host_link_config (
    input wire sys_clk,
    input wire rst_n,
    input wire [8:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    input wire sample_marked,
    input wire application_fuse_reload,
    output reg application_fuse_lock,
    output reg fuse_access_unlocked,
    output reg loading,
    output reg [7:0] temperature_offset,
    input wire [7:0] tw_addr_byte,
    input wire tw_addr_valid,
    input wire tw_on_hs_link,
    output reg tw_addr_match,
    output reg tw_page_high,
    output reg tw_read,
    output reg [3:0] tw_base_in_use,
    output reg primary_link_two_wire,
    output reg primary_link_hs_continuous,
    output reg primary_link_fast_plus,
    input wire serial_clock_pin,
    input wire chip_select_pin,
    input wire link_rw_flag,
    output reg link_selected,
    output reg link_sample_pulse,
    output reg link_shift_pulse,
    output reg link_is_read,
    input wire core_irq,
    input wire core_reset,
    output reg interrupt_request_out_o,
    output reg interrupt_request_out_oe_n,
    output reg reset_request_out_o,
    output reg reset_request_out_oe_n
);
    localparam ST_IDLE = 3'd0;
    localparam ST_LD_ISSUE = 3'd1;
    localparam ST_LD_TAKE = 3'd2;
    localparam ST_HR_ISSUE = 3'd3;
    localparam ST_HR_TAKE = 3'd4;

    reg [2:0] state;
    reg [1:0] load_idx;
    reg [7:0] fuse_array_address;
    reg [7:0] fuse_data_port;
    reg [7:0] host_link_setup;
    reg [7:0] host_link_and_output_config;
    reg [1:0] seq_cnt;
    reg sck_s1, sck_s2, sck_s3;
    reg cs_s1, cs_s2;

    reg mem_rd_en;
    reg [7:0] mem_rd_addr;
    wire [7:0] mem_rd_data;
    reg mem_wr_en;

    wire if_writable = ~sample_marked & ~application_fuse_lock;
    wire wr_addr_reg = reg_wr && (reg_addr == `HLC_OFS_FUSE_ADDR);
    wire wr_data_reg = reg_wr && (reg_addr == `HLC_OFS_FUSE_DATA);
    wire in_app_range = (fuse_array_address >= `HLC_FUSE_APP_FIRST) &&
                        (fuse_array_address <= `HLC_FUSE_APP_LAST);
    wire [7:0] key_now = (seq_cnt == 2'h0) ? `HLC_CHIP_CODE :
                         (seq_cnt == 2'h1) ? `HLC_KEY0 :
                         (seq_cnt == 2'h2) ? `HLC_KEY1 : `HLC_KEY2;

    hlc_fuse_mem u_mem (
        .sys_clk(sys_clk),
        .rd_en(mem_rd_en),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data),
        .wr_en(mem_wr_en),
        .wr_addr(fuse_array_address),
        .wr_data(fuse_data_port)
    );

    always @*
    begin
        mem_rd_en = 1'b0;
        mem_rd_addr = fuse_array_address;
        if (state == ST_LD_ISSUE)
        begin
            mem_rd_en = 1'b1;
            case (load_idx)
                2'h0: mem_rd_addr = `HLC_FUSE_T_OFFSET;
                2'h1: mem_rd_addr = `HLC_FUSE_SETUP;
                2'h2: mem_rd_addr = `HLC_FUSE_CFG;
                default: mem_rd_addr = `HLC_FUSE_LOCK;
            endcase
        end
        else if (state == ST_HR_ISSUE)
        begin
            mem_rd_en = 1'b1;
        end
    end

    // fusing needs unlock, and the locked application range refuses it
    always @*
    begin
        mem_wr_en = 1'b0;
        if (fuse_access_unlocked && wr_data_reg && state == ST_IDLE)
        begin
            mem_wr_en = ~(in_app_range & application_fuse_lock);
        end
    end

    // fuse memory write uses the data byte already held; new byte lands afterwards
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_LD_ISSUE;
            load_idx <= 2'h0;
            seq_cnt <= 2'h0;
            fuse_access_unlocked <= 1'b0;
            fuse_array_address <= `HLC_RST_BYTE;
            fuse_data_port <= `HLC_RST_BYTE;
            temperature_offset <= `HLC_RST_BYTE;
            host_link_setup <= `HLC_RST_BYTE;
            host_link_and_output_config <= `HLC_RST_BYTE;
            application_fuse_lock <= 1'b0;
            loading <= 1'b1;
        end
        else
        begin
            // unlock sequence travels through the address register
            if (wr_addr_reg)
            begin
                fuse_array_address <= reg_wdata;
                if (!fuse_access_unlocked)
                begin
                    if (reg_wdata == key_now)
                    begin
                        seq_cnt <= seq_cnt + 2'h1;
                        if (seq_cnt == `HLC_SEQ_LAST)
                        begin
                            fuse_access_unlocked <= 1'b1;
                        end
                    end
                    else
                    begin
                        seq_cnt <= 2'h0;
                    end
                end
            end
            if (wr_data_reg)
            begin
                fuse_data_port <= reg_wdata;
            end
            if (reg_wr && reg_addr == `HLC_OFS_LINK_SETUP && if_writable)
            begin
                host_link_setup <= reg_wdata;
            end
            // bit 7 only when interface writable, others always
            if (reg_wr && reg_addr == `HLC_OFS_LINK_CFG)
            begin
                host_link_and_output_config[6:0] <= reg_wdata[6:0];
                if (if_writable)
                begin
                    host_link_and_output_config[7] <= reg_wdata[7];
                end
            end
            case (state)
                ST_IDLE:
                begin
                    if (application_fuse_reload)
                    begin
                        state <= ST_LD_ISSUE;
                        load_idx <= 2'h0;
                        loading <= 1'b1;
                    end
                    else if (wr_addr_reg && fuse_access_unlocked)
                    begin
                        state <= ST_HR_ISSUE;
                    end
                end
                ST_LD_ISSUE:
                begin
                    state <= ST_LD_TAKE;
                end
                ST_LD_TAKE:
                begin
                    case (load_idx)
                        2'h0: temperature_offset <= mem_rd_data;
                        2'h1: host_link_setup <= mem_rd_data;
                        2'h2: host_link_and_output_config <= mem_rd_data;
                        default: application_fuse_lock <= mem_rd_data[0];
                    endcase
                    if (load_idx == `HLC_LOAD_LAST)
                    begin
                        state <= ST_IDLE;
                        loading <= 1'b0;
                    end
                    else
                    begin
                        load_idx <= load_idx + 2'h1;
                        state <= ST_LD_ISSUE;
                    end
                end
                ST_HR_ISSUE:
                begin
                    state <= ST_HR_TAKE;
                end
                ST_HR_TAKE:
                begin
                    if (!wr_data_reg)
                    begin
                        fuse_data_port <= mem_rd_data;
                    end
                    state <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // register read port, answer one cycle after the strobe
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= `HLC_RST_BYTE;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
            begin
                case (reg_addr)
                    `HLC_OFS_FUSE_ADDR: reg_rdata <= fuse_array_address;
                    `HLC_OFS_FUSE_DATA: reg_rdata <= fuse_data_port;
                    `HLC_OFS_TEMP_OFS: reg_rdata <= temperature_offset;
                    `HLC_OFS_LINK_SETUP: reg_rdata <= host_link_setup;
                    `HLC_OFS_LINK_CFG: reg_rdata <= host_link_and_output_config;
                    default: reg_rdata <= `HLC_RST_BYTE;
                endcase
            end
        end
    end

    // 2-wire address decode
    wire [3:0] base_field = host_link_setup[`HLC_SETUP_BASE_HI:`HLC_SETUP_BASE_LO];
    wire [3:0] base_eff = (base_field == `HLC_BASE_UNPROG) ? `HLC_DEFAULT_BASE : base_field;

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tw_addr_match <= 1'b0;
            tw_page_high <= 1'b0;
            tw_read <= 1'b0;
            tw_base_in_use <= 4'h0;
            primary_link_two_wire <= 1'b0;
            primary_link_hs_continuous <= 1'b0;
            primary_link_fast_plus <= 1'b0;
        end
        else
        begin
            tw_base_in_use <= base_eff;
            primary_link_two_wire <= host_link_and_output_config[`HLC_CFG_TWO_WIRE];
            primary_link_hs_continuous <= host_link_and_output_config[`HLC_CFG_HS_CONT];
            primary_link_fast_plus <= host_link_and_output_config[`HLC_CFG_FAST_PLUS];
            // hs bit of the low nibble picks the link: 0 primary, 1 high speed
            tw_addr_match <= tw_addr_valid && tw_addr_byte[7:4] == base_eff &&
                             !tw_addr_byte[`HLC_TW_ZERO_BIT] && tw_addr_byte[`HLC_TW_HS_BIT] == tw_on_hs_link;
            if (tw_addr_valid)
            begin
                tw_page_high <= tw_addr_byte[`HLC_TW_PAGE_BIT];
                tw_read <= tw_addr_byte[`HLC_TW_RW_BIT];
            end
        end
    end

    // 4-wire framing: clock and select pins pass two flops before any logic sees them; the read/write flag goes straight in
    wire cpol = host_link_setup[`HLC_SETUP_CPOL];
    wire cpha = host_link_setup[`HLC_SETUP_CPHA];
    wire sel_pol = host_link_setup[`HLC_SETUP_SELPOL];
    wire sck_rise = sck_s2 & ~sck_s3;
    wire sck_fall = ~sck_s2 & sck_s3;
    wire lead_edge = cpol ? sck_fall : sck_rise;
    wire trail_edge = cpol ? sck_rise : sck_fall;
    wire sel_now = sel_pol ? cs_s2 : ~cs_s2;

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            cs_s1 <= 1'b0;
            cs_s2 <= 1'b0;
            link_selected <= 1'b0;
            link_sample_pulse <= 1'b0;
            link_shift_pulse <= 1'b0;
            link_is_read <= 1'b0;
        end
        else
        begin
            sck_s1 <= serial_clock_pin;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            cs_s1 <= chip_select_pin;
            cs_s2 <= cs_s1;
            link_selected <= sel_now;
            // phase 0 samples on leading edge; held off while loading, flops reset low fake an edge
            link_sample_pulse <= sel_now & ~loading & (cpha ? trail_edge : lead_edge);
            link_shift_pulse <= sel_now & ~loading & (cpha ? lead_edge : trail_edge);
            link_is_read <= link_rw_flag == host_link_setup[`HLC_SETUP_RDPOL];
        end
    end

    // pad drivers: oe_n low while the pin is driven
    wire irq_level = core_irq ~^ host_link_and_output_config[`HLC_CFG_IRQ_POL];
    wire od = host_link_and_output_config[`HLC_CFG_DRIVE];

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            interrupt_request_out_o <= 1'b0;
            interrupt_request_out_oe_n <= 1'b1;
            reset_request_out_o <= 1'b0;
            reset_request_out_oe_n <= 1'b1;
        end
        else
        begin
            // open drain only ever pulls low; a high level comes from the pull-up
            interrupt_request_out_o <= od ? 1'b0 : irq_level;
            interrupt_request_out_oe_n <= od ? irq_level : 1'b0;
            reset_request_out_o <= od ? 1'b0 : ~core_reset;
            reset_request_out_oe_n <= od ? ~core_reset : 1'b0;
        end
    end
endmodule

// ===== tb/hlc_host_link_config_props.sv
// assertion checker for the host link config bank
`timescale 1ns/1ps
`include "hlc_consts.vh"
module hlc_host_link_config_chk (
    input wire sys_clk,
    input wire rst_n,
    input wire [8:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    input wire application_fuse_reload,
    input wire loading,
    input wire fuse_access_unlocked,
    input wire [7:0] tw_addr_byte,
    input wire tw_addr_valid,
    input wire tw_addr_match,
    input wire tw_page_high,
    input wire tw_read,
    input wire primary_link_hs_continuous,
    input wire primary_link_fast_plus,
    input wire core_reset,
    input wire interrupt_request_out_o,
    input wire interrupt_request_out_oe_n,
    input wire reset_request_out_o,
    input wire reset_request_out_oe_n
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_n);
read_answer_a:
    assert property (reg_rd |=> reg_rvalid) else $error("read got no answer");
answer_cause_a:
    assert property (reg_rvalid |-> $past(reg_rd)) else $error("answer without read");
unmapped_zero_a:
    assert property (reg_rd && (reg_addr < `HLC_OFS_FUSE_ADDR || reg_addr > `HLC_OFS_LINK_CFG) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
unlock_key_a:
    assert property ($rose(fuse_access_unlocked) |-> $past(reg_wr) && $past(reg_addr) == `HLC_OFS_FUSE_ADDR
        && $past(reg_wdata) == `HLC_KEY2) else $error("unlock without last key");
hs_mode_wr_a:
    assert property (reg_wr && reg_addr == `HLC_OFS_LINK_CFG && !loading && !application_fuse_reload
        ##1 !(reg_wr && reg_addr == `HLC_OFS_LINK_CFG)
        |=> primary_link_hs_continuous == $past(reg_wdata[6], 2)) else $error("hs bit not written");
fast_plus_wr_a:
    assert property (reg_wr && reg_addr == `HLC_OFS_LINK_CFG && !loading && !application_fuse_reload
        ##1 !(reg_wr && reg_addr == `HLC_OFS_LINK_CFG)
        |=> primary_link_fast_plus == $past(reg_wdata[5], 2)) else $error("fast plus bit not written");
addr_flags_a:
    assert property (tw_addr_valid |=> tw_read == $past(tw_addr_byte[0]) && tw_page_high == $past(tw_addr_byte[1]))
    else $error("address flags wrong");
match_cause_a:
    assert property (tw_addr_match |-> $past(tw_addr_valid)) else $error("match without address");
reset_pad_a:
    assert property (core_reset && !loading |=> !reset_request_out_o && !reset_request_out_oe_n)
    else $error("reset pad not pulled low");
irq_drive_a:
    assert property (interrupt_request_out_o |-> !interrupt_request_out_oe_n) else $error("irq high while undriven");
endmodule
bind hlc_host_link_config hlc_host_link_config_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .application_fuse_reload(application_fuse_reload), .loading(loading),
    .fuse_access_unlocked(fuse_access_unlocked), .tw_addr_byte(tw_addr_byte), .tw_addr_valid(tw_addr_valid),
    .tw_addr_match(tw_addr_match), .tw_page_high(tw_page_high), .tw_read(tw_read),
    .primary_link_hs_continuous(primary_link_hs_continuous), .primary_link_fast_plus(primary_link_fast_plus),
    .core_reset(core_reset), .interrupt_request_out_o(interrupt_request_out_o),
    .interrupt_request_out_oe_n(interrupt_request_out_oe_n), .reset_request_out_o(reset_request_out_o),
    .reset_request_out_oe_n(reset_request_out_oe_n));

// ===== tb/hlc_host_model.sv
// host model driving the 4-wire pins, clock runs only inside frames
`timescale 1ns/1ps
module hlc_host_model #(
    parameter HALF_NS = 32
) (
    input wire start,
    input wire cpol,
    input wire selpol,
    input wire rd_pol,
    input wire read_req,
    output reg serial_clock_pin,
    output reg chip_select_pin,
    output reg link_rw_flag,
    output reg busy
);
integer k;
// idle levels match the polarity the bench ties on
initial
begin
    busy = 1'b0;
    serial_clock_pin = 1'b1;
    chip_select_pin = 1'b0;
    link_rw_flag = 1'b0;
end
always @(posedge start)
begin
    busy = 1'b1;
    serial_clock_pin = cpol;
    link_rw_flag = read_req ~^ rd_pol;
    #(HALF_NS) chip_select_pin = selpol;
    for (k = 0; k < 16; k = k + 1)
        #(HALF_NS) serial_clock_pin = ~serial_clock_pin;
    #(HALF_NS) chip_select_pin = ~selpol;
    // flag no longer qualified, so show the inverse rather than a stale value
    link_rw_flag = ~link_rw_flag;
    busy = 1'b0;
end
endmodule

// ===== tb/test_hlc_host_link_config.sv
// self-checking bench for the host link config bank
`timescale 1ns/1ps
`include "hlc_consts.vh"
module test_hlc_host_link_config;
reg sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sample_marked = 1'b1, reload = 1'b0;
reg tw_addr_valid = 1'b0, tw_on_hs_link = 1'b0, core_irq = 1'b0, core_reset = 1'b1, host_go = 1'b0, host_rd = 1'b0;
reg [8:0] reg_addr = 9'h000;
reg [7:0] reg_wdata = 8'h00, tw_addr_byte = 8'h00, v;
reg [7:0] n_smp = 8'h00, n_sft = 8'h00, s0, s1;
reg pol, drv, lvl, ahead = 1'b0;
integer n_mismatch = 0, n_compared = 0, m, i;
wire [7:0] reg_rdata;
wire reg_rvalid, unl, loading, page_hi, rd_flag, hs, fp, sck, cs, rw, irq_o, irq_oe_n, rst_o, rst_oe_n, busy;
wire lock, tw_match, two_w, sel, smp_p, sft_p, is_rd;
wire [7:0] t_ofs;
wire [3:0] base;
always #2.5 sys_clk = ~sys_clk;
hlc_host_link_config u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sample_marked(sample_marked), .application_fuse_reload(reload), .application_fuse_lock(lock),
    .fuse_access_unlocked(unl), .loading(loading), .temperature_offset(t_ofs), .tw_addr_byte(tw_addr_byte),
    .tw_addr_valid(tw_addr_valid), .tw_on_hs_link(tw_on_hs_link), .tw_addr_match(tw_match),
    .tw_page_high(page_hi), .tw_read(rd_flag), .tw_base_in_use(base), .primary_link_two_wire(two_w),
    .primary_link_hs_continuous(hs), .primary_link_fast_plus(fp), .serial_clock_pin(sck),
    .chip_select_pin(cs), .link_rw_flag(rw), .link_selected(sel), .link_sample_pulse(smp_p),
    .link_shift_pulse(sft_p), .link_is_read(is_rd), .core_irq(core_irq),
    .core_reset(core_reset), .interrupt_request_out_o(irq_o), .interrupt_request_out_oe_n(irq_oe_n),
    .reset_request_out_o(rst_o), .reset_request_out_oe_n(rst_oe_n));
hlc_host_model u_host (.start(host_go), .cpol(1'b1), .selpol(1'b1), .rd_pol(1'b1), .read_req(host_rd),
    .serial_clock_pin(sck), .chip_select_pin(cs), .link_rw_flag(rw), .busy(busy));
task wrap_up;
begin
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
end
endtask
task check(input [7:0] got, input [7:0] exp);
begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
end
endtask
task timeout;
begin
    n_mismatch = n_mismatch + 1;
    $display("Error at %0t: wait ran out", $time);
    wrap_up;
end
endtask
task tick(input integer n);
begin
    repeat (n) @(posedge sys_clk);
    #1;
end
endtask
task wr(input [8:0] a, input [7:0] d);
begin
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
end
endtask
task rd(input [8:0] a, output [7:0] d);
integer k;
begin
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    for (k = 0; k < 4 && reg_rvalid !== 1'b1; k = k + 1)
        tick(1);
    if (reg_rvalid !== 1'b1)
        timeout;
    d = reg_rdata;
    tick(1);
end
endtask
task wait_load;
integer k;
begin
    for (k = 0; k < 20 && loading !== 1'b0; k = k + 1)
        tick(1);
    if (loading !== 1'b0)
        timeout;
end
endtask
task fuse(input [7:0] a, input [7:0] d);
begin
    // first data write fuses the byte read back from a, the second fuses d
    wr(`HLC_OFS_FUSE_ADDR, a);
    tick(2);
    wr(`HLC_OFS_FUSE_DATA, d);
    wr(`HLC_OFS_FUSE_DATA, d);
end
endtask
task reload_all;
begin
    reload = 1'b1;
    tick(1);
    reload = 1'b0;
    check({7'h0, loading}, 8'h01);
    wait_load;
end
endtask
always @(posedge sys_clk)
begin
    if (smp_p)
        n_smp <= n_smp + 8'h01;
    if (sft_p)
        n_sft <= n_sft + 8'h01;
end
initial
begin
    repeat (10) @(posedge sys_clk);
    #1;
    check({reg_rvalid, loading, irq_oe_n, rst_oe_n, 4'h0}, 8'h70);
    check(reg_rdata, 8'h00);
    rst_n = 1'b1;
    wait_load;
    check({4'h0, base}, 8'h0b);
    // unmarked sample with the lock clear may change the link setup
    sample_marked = 1'b0;
    wr(`HLC_OFS_LINK_SETUP, 8'h0f);
    rd(`HLC_OFS_LINK_SETUP, v);
    check(v, 8'h0f);
    sample_marked = 1'b1;
    // a wrong key must restart the sequence
    wr(`HLC_OFS_FUSE_ADDR, `HLC_CHIP_CODE);
    wr(`HLC_OFS_FUSE_ADDR, `HLC_KEY0);
    wr(`HLC_OFS_FUSE_ADDR, 8'h99);
    wr(`HLC_OFS_FUSE_ADDR, `HLC_KEY2);
    tick(1);
    check({7'h0, unl}, 8'h00);
    wr(`HLC_OFS_FUSE_ADDR, `HLC_CHIP_CODE);
    wr(`HLC_OFS_FUSE_ADDR, `HLC_KEY0);
    wr(`HLC_OFS_FUSE_ADDR, `HLC_KEY1);
    tick(1);
    check({7'h0, unl}, 8'h00);
    wr(`HLC_OFS_FUSE_ADDR, `HLC_KEY2);
    tick(1);
    check({7'h0, unl}, 8'h01);
    fuse(8'h40, 8'hff);
    wr(`HLC_OFS_FUSE_ADDR, 8'h00);
    tick(2);
    wr(`HLC_OFS_FUSE_ADDR, 8'h40);
    tick(2);
    rd(`HLC_OFS_FUSE_DATA, v);
    check(v, 8'hff);
    rd(`HLC_OFS_FUSE_ADDR, v);
    check(v, 8'h40);
    fuse(`HLC_FUSE_T_OFFSET, 8'h80);
    fuse(`HLC_FUSE_SETUP, 8'hbf);
    fuse(`HLC_FUSE_CFG, 8'h80);
    fuse(`HLC_FUSE_LOCK, 8'h01);
    reload_all;
    rd(`HLC_OFS_TEMP_OFS, v);
    check(v, 8'h80);
    check(t_ofs, 8'h80);
    check({lock, two_w, base, 2'b00}, 8'hec);
    // locked range refuses fusing, so a reload brings back the old offset
    fuse(`HLC_FUSE_T_OFFSET, 8'h01);
    reload_all;
    wr(`HLC_OFS_TEMP_OFS, 8'h5a);
    rd(`HLC_OFS_TEMP_OFS, v);
    check(v, 8'h80);
    sample_marked = 1'b0;
    wr(`HLC_OFS_LINK_SETUP, 8'h5a);
    rd(`HLC_OFS_LINK_SETUP, v);
    check(v, 8'hbf);
    sample_marked = 1'b1;
    rd(9'h1ff, v);
    check(v, 8'h00);
    for (m = 0; m < 4; m = m + 1)
    begin
        pol = m[1];
        drv = m[0];
        wr(`HLC_OFS_LINK_CFG, {1'b0, drv, ~drv, 1'b0, pol, drv, 2'b00});
        rd(`HLC_OFS_LINK_CFG, v);
        check(v, {1'b1, drv, ~drv, 1'b0, pol, drv, 2'b00});
        check({6'h0, hs, fp}, {6'h0, drv, ~drv});
        for (i = 0; i < 2; i = i + 1)
        begin
            core_irq = i[0];
            core_reset = i[0];
            tick(2);
            lvl = ~(i[0] ^ pol);
            check({6'h0, irq_o, irq_oe_n}, drv ? {7'h0, lvl} : {6'h0, lvl, 1'b0});
            check({6'h0, rst_o, rst_oe_n}, drv ? {7'h0, ~i[0]} : {6'h0, ~i[0], 1'b0});
        end
    end
    // 0xb8 and 0xc0 lie outside the device's eight addresses
    tw_addr_valid = 1'b1;
    for (m = 0; m < 10; m = m + 1)
    begin
        tw_addr_byte = (m == 9) ? 8'hc0 : 8'hb0 + m[7:0];
        tw_on_hs_link = tw_addr_byte[2];
        tick(1);
        check({5'h0, tw_match, page_hi, rd_flag}, {5'h0, m < 8, tw_addr_byte[1:0]});
    end
    tw_addr_valid = 1'b0;
    for (m = 0; m < 2; m = m + 1)
    begin
        host_rd = m[0];
        s0 = n_smp;
        s1 = n_sft;
        host_go = 1'b1;
        tick(1);
        host_go = 1'b0;
        tick(40);
        check({6'h0, sel, is_rd}, {6'h0, 1'b1, m[0]});
        // phase 1 shifts on the leading edge, so samples never run ahead of shifts
        for (i = 0; i < 300 && busy !== 1'b0; i = i + 1)
        begin
            tick(1);
            if (n_smp - s0 > n_sft - s1)
                ahead = 1'b1;
        end
        if (busy !== 1'b0)
            timeout;
        check(n_smp - s0, 8'h08);
        check(n_sft - s1, 8'h08);
    end
    check({7'h0, ahead}, 8'h00);
    tick(4);
    wrap_up;
end
endmodule
